// file: dv/gtr_plant.sv
// Battery bank and grid input model facing the transfer block
`timescale 1ns/1ps
module gtr_plant #(
  parameter logic [15:0] OFS = 16'h0100
) (
  input wire logic ref_clk,
  output logic [15:0] batt_volts,
  output logic [15:0] batt_comp_volts,
  output logic grid_present
);
  // Fixed sensor offset; a real bank drifts with temperature
  initial begin
    batt_volts = 16'h4000;
    batt_comp_volts = 16'h4100;
    grid_present = 1'b0;
  end
  task automatic set(input logic [15:0] v, input logic g);
    @(posedge ref_clk);
    batt_volts <= v;
    batt_comp_volts <= v + OFS;
    grid_present <= g;
  endtask
endmodule

// file: dv/gtr_top_asserts.sv
// Assertion checker for the grid transfer relay block
`timescale 1ns/1ps
module gtr_top_asserts #(
  parameter longint QUAL = 20,
  parameter longint REACT = 10
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic [15:0] batt_volts,
  input wire logic [15:0] batt_comp_volts,
  input wire logic grid_present,
  input wire logic grid_in_tol,
  input wire logic inv_output_ok,
  input wire logic cooldown_req,
  input wire logic grid_connect,
  input wire logic grid_charge,
  input wire logic load_control_relay,
  input wire logic charge_control_relay,
  input wire logic output_fault_relay
);
  logic mode_r, fm_r;
  logic [15:0] hi_r, lo_r;
  logic [31:0] lcr_r, ccr_r, tm_r;
  logic [7:0] lo_cnt, on_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Raw written values; bench has transfer levels inside the cut-outs before it enters transfer mode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_r <= 1'b0;
      fm_r <= 1'b0;
      hi_r <= 16'hffff;
      lo_r <= 16'h0;
      lcr_r <= 32'hffff0000;
      ccr_r <= 32'hffff0000;
      tm_r <= 32'h0;
    end else if (avs_write && !avs_waitrequest) begin
      case (avs_address)
        4'h0: begin
          mode_r <= avs_writedata[0];
          fm_r <= avs_writedata[1];
        end
        4'h1: hi_r <= avs_writedata[15:0];
        4'h2: lo_r <= avs_writedata[15:0];
        4'h5: lcr_r <= avs_writedata;
        4'h6: ccr_r <= avs_writedata;
        4'h4: tm_r <= avs_writedata;
        default: ;
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lo_cnt <= 8'h0;
      on_cnt <= 8'h0;
    end else begin
      lo_cnt <= (batt_volts <= lo_r) ? lo_cnt + 8'(lo_cnt != 8'hff) : 8'h0;
      on_cnt <= (batt_volts >= lcr_r[31:16]) ? on_cnt + 8'(on_cnt != 8'hff) : 8'h0;
    end
  end
  sequence s_bx_grid;
    mode_r && grid_connect;
  endsequence
  chk_rst_quiet: assert property ($fell(sys_rst) |-> !grid_connect && !load_control_relay && !output_fault_relay)
    else $error("outputs active after reset");
  chk_bus_ack: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus not answered in one cycle");
  chk_sb_follow: assert property (!mode_r && !$past(mode_r) && !$past(sys_rst) && tm_r[12:0] == tm_r[28:16] &&
    $past(tm_r[12:0] == tm_r[28:16]) |-> grid_connect == $past(grid_present && grid_in_tol))
    else $error("standby grid connect wrong");
  chk_bx_nocharge: assert property (mode_r && $past(mode_r) |-> !grid_charge)
    else $error("charging in transfer mode");
  chk_xfer_qual: assert property (mode_r && $rose(grid_connect) |-> lo_cnt >= QUAL)
    else $error("transfer to grid too early");
  chk_xfer_back: assert property (s_bx_grid ##0 batt_volts >= hi_r |-> ##2 !grid_connect)
    else $error("no prompt return to inverter");
  chk_lcr_react: assert property ($rose(load_control_relay) |-> on_cnt >= REACT)
    else $error("load relay energized too early");
  chk_ccr_drop: assert property (batt_comp_volts <= ccr_r[15:0] |=> !charge_control_relay)
    else $error("charge relay not dropped");
  chk_fault_err: assert property (!fm_r && !$past(fm_r) && !$past(sys_rst) |-> output_fault_relay == $past(inv_output_ok))
    else $error("fault relay error mode wrong");
  chk_fault_cool: assert property (fm_r && $past(fm_r) |-> output_fault_relay == !$past(cooldown_req))
    else $error("fault relay cooldown mode wrong");
endmodule

// file: dv/gtr_top_tb_top.sv
// Self-checking bench for the grid transfer relay block
`timescale 1ns/1ps
`include "gtr_defs.svh"
module gtr_top_tb_top;
  typedef struct {logic [31:0] e; logic [31:0] m;} gtr_exp_t;
  gtr_exp_t expq[$];
  gtr_exp_t x;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic inv_output_ok = 1'b0;
  logic cooldown_req = 1'b0;
  logic clk_en = 1'b1;
  logic grid_in_tol = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [15:0] batt_volts, batt_comp_volts;
  logic [4:0] tod_hour = 5'h00;
  logic avs_waitrequest, grid_present, grid_connect, grid_charge;
  logic load_control_relay, charge_control_relay, output_fault_relay;
  int n_fail = 0;
  int compares = 0;
  int seed = 92;
  always #2.5 ref_clk = ~ref_clk;
  gtr_plant u_gtr_plant (.ref_clk, .batt_volts, .batt_comp_volts, .grid_present);
  gtr_top #(.LBX_QUAL_CYC(20), .LCR_REACT_CYC(10), .MIN_CYC(5)) u_gtr_top (
    .ref_clk, .sys_rst, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .batt_volts, .batt_comp_volts, .grid_present,
    .grid_in_tol, .tod_hour, .tod_min(6'h0), .inv_output_ok, .cooldown_req,
    .grid_connect, .grid_charge, .grid_silent(), .load_control_relay, .charge_control_relay,
    .output_fault_relay);
  task automatic final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Waitrequest is read at the rising edge, before that edge's updates land
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 40) begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 40) begin
      n_fail++;
      final_report();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    expq.push_back('{e, m});
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && expq.size() > 0) begin
      x = expq.pop_front();
      compares++;
      if ((avs_readdata & x.m) !== x.e) begin
        n_fail++;
        $display("FAIL reg %h exp %h seen %h", avs_address, x.e, avs_readdata & x.m);
      end
    end
  end
  initial begin
    logic [31:0] v;
    logic f, b;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(`GTR_ADDR_CTRL, 32'h0, 32'h7);
    rd(`GTR_ADDR_STATUS, 32'h0, 32'h1d);
    rd(4'hf, 32'h0, 32'hffffffff);
    // Usage timer stays disabled for these standby grid checks
    for (int g = 0; g < 2; g++) begin
      u_gtr_plant.set(16'h4000, g[0]);
      wt(3);
      rd(`GTR_ADDR_STATUS, 32'(g[0]), 32'h1);
    end
    grid_in_tol <= 1'b0;
    wt(3);
    rd(`GTR_ADDR_STATUS, 32'h0, 32'h1);
    grid_in_tol <= 1'b1;
    bus(`GTR_ADDR_TIMER, 1'b1, 32'h02000100);
    wt(2);
    rd(`GTR_ADDR_STATUS, 32'h80, 32'hc1);
    tod_hour <= 5'h01;
    wt(3);
    rd(`GTR_ADDR_STATUS, 32'hc1, 32'hc1);
    bus(`GTR_ADDR_TIMER, 1'b1, 32'h0);
    wt(2);
    $display("standby done");
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      f = i[0];
      b = f ? ~v[1] : v[0];
      inv_output_ok <= v[0];
      cooldown_req <= v[1];
      bus(`GTR_ADDR_CTRL, 1'b1, 32'(f) << 1);
      wt(2);
      rd(`GTR_ADDR_STATUS, 32'(b) << 4, 32'h10);
    end
    $display("fault relay done");
    bus(`GTR_ADDR_LCR, 1'b1, 32'h80001000);
    v = $random(seed);
    u_gtr_plant.set({1'b1, v[14:0]}, 1'b0);
    wt(3);
    u_gtr_plant.set(16'h5000, 1'b0);
    u_gtr_plant.set({1'b1, v[14:0]}, 1'b0);
    wt(4);
    rd(`GTR_ADDR_STATUS, 32'h0, 32'h4);
    wt(12);
    rd(`GTR_ADDR_STATUS, 32'h4, 32'h4);
    u_gtr_plant.set(16'h0800, 1'b0);
    rd(`GTR_ADDR_STATUS, 32'h4, 32'h4);
    wt(10);
    rd(`GTR_ADDR_STATUS, 32'h0, 32'h4);
    $display("load relay done");
    bus(`GTR_ADDR_CCR, 1'b1, 32'h80004000);
    u_gtr_plant.set(16'h8000, 1'b0);
    wt(12);
    rd(`GTR_ADDR_STATUS, 32'h8, 32'h8);
    u_gtr_plant.set(16'h3e00, 1'b0);
    rd(`GTR_ADDR_STATUS, 32'h0, 32'h8);
    $display("charge relay done");
    bus(`GTR_ADDR_CUTOUT, 1'b1, 32'h60002000);
    bus(4'h1, 1'b1, 32'hffff);
    rd(4'h1, 32'h6000, 32'hffff);
    bus(4'h2, 1'b1, 32'h0);
    rd(4'h2, 32'h2000, 32'hffff);
    bus(4'h1, 1'b1, 32'h5000);
    bus(4'h2, 1'b1, 32'h2000);
    bus(`GTR_ADDR_CTRL, 1'b1, 32'h1);
    u_gtr_plant.set(16'h1800, 1'b1);
    wt(5);
    rd(`GTR_ADDR_STATUS, 32'h0, 32'h3);
    wt(25);
    rd(`GTR_ADDR_STATUS, 32'h1, 32'h3);
    u_gtr_plant.set(16'h4f80, 1'b1);
    wt(3);
    rd(`GTR_ADDR_STATUS, 32'h1, 32'h1);
    u_gtr_plant.set(16'h5000, 1'b1);
    wt(1);
    rd(`GTR_ADDR_STATUS, 32'h0, 32'h1);
    $display("transfer done");
    final_report();
  end
endmodule
bind gtr_top gtr_top_asserts #(.QUAL(LBX_QUAL_CYC), .REACT(LCR_REACT_CYC)) u_gtr_top_asserts (.*);

// file: hw/gtr_defs.svh
// Offsets, field positions, reset values and timing counts for the grid transfer relay block
`ifndef GTR_DEFS_SVH
`define GTR_DEFS_SVH
// Held at 64 bits so the cycle products below do not wrap
`define GTR_CLK_HZ 64'h000000000bebc200
`define GTR_LBX_QUAL_S 10
`define GTR_LBX_QUAL_CYC (`GTR_LBX_QUAL_S * `GTR_CLK_HZ)
`define GTR_LCR_REACT_S 2
`define GTR_LCR_REACT_CYC (`GTR_LCR_REACT_S * `GTR_CLK_HZ)
`define GTR_MIN_S 60
`define GTR_MIN_CYC (`GTR_MIN_S * `GTR_CLK_HZ)
`define GTR_ADDR_CTRL 4'h0
`define GTR_ADDR_HBX 4'h1
`define GTR_ADDR_LBX 4'h2
`define GTR_ADDR_CUTOUT 4'h3
`define GTR_ADDR_TIMER 4'h4
`define GTR_ADDR_LCR 4'h5
`define GTR_ADDR_CCR 4'h6
`define GTR_ADDR_DELAY 4'h7
`define GTR_ADDR_STATUS 4'h8
`define GTR_CTRL_MODE_BIT 0
`define GTR_CTRL_FAULT_BIT 1
`define GTR_CTRL_SILENT_BIT 2
`define GTR_CTRL_RST 3'h0
`endif

// file: hw/gtr_pkg.sv
// Types shared by the grid transfer relay block
package gtr_pkg;
  typedef enum logic {GTR_STANDBY, GTR_BATT_XFER} gtr_mode_t;
  typedef enum logic [1:0] {GTR_ON_INV, GTR_ON_GRID, GTR_GRID_WAIT} gtr_xfer_t;
endpackage

// file: hw/gtr_qual_timer.sv
// Qualification counter: condition must hold for limit cycles
`timescale 1ns/1ps
module gtr_qual_timer #(
  parameter int W = 40
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  gtr_tick_if.tmr q
);
  logic [W-1:0] cnt_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      if (!q.cond) begin
        cnt_r <= '0;
      end else if (cnt_r < q.limit) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
  assign q.done = q.cond && (cnt_r >= q.limit);
endmodule

// file: hw/gtr_tick_if.sv
// Qualification timer request and status carried between top and counter
`timescale 1ns/1ps
interface gtr_tick_if #(parameter int W = 40);
  logic cond;
  logic [W-1:0] limit;
  logic done;
  modport ctl (output cond, output limit, input done);
  modport tmr (input cond, input limit, output done);
endinterface

// file: hw/gtr_top.sv
// Grid transfer decision, grid usage timer and auxiliary relay drives
//
// Summary of operation
// - Two grid modes; standby backup after reset
// - Standby: grid maintains battery, else invert
// - Transfer mode: battery until low threshold, then grid
// - Low threshold must hold ten seconds
// - Back to inverter at high threshold, immediately
// - Transfer mode never charges from grid
// - Thresholds use uncompensated volts, transfer mode only
// - Thresholds clamped between battery cut-out levels
// - Begin time opens grid; charge or silent
// - Times held as 24-hour hour and minute
// - Equal begin and end disables timer
// - End time closes grid; standby mode only
// - Relays run whether inverter on or off
// - Load relay energizes after two-second delay
// - Load relay drops after minutes below threshold
// - Charge relay energizes after compensated delay
// - Fault relay: error or cooldown drive
// - Charge relay drops immediately at threshold
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "gtr_defs.svh"
module gtr_top #(
  parameter int VW = 16,
  parameter longint LBX_QUAL_CYC = `GTR_LBX_QUAL_CYC,
  parameter longint LCR_REACT_CYC = `GTR_LCR_REACT_CYC,
  parameter longint MIN_CYC = `GTR_MIN_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [VW-1:0] batt_volts,
  input wire logic [VW-1:0] batt_comp_volts,
  input wire logic grid_present,
  input wire logic grid_in_tol,
  input wire logic [4:0] tod_hour,
  input wire logic [5:0] tod_min,
  input wire logic inv_output_ok,
  input wire logic cooldown_req,
  output logic grid_connect,
  output logic grid_charge,
  output logic grid_silent,
  output logic load_control_relay,
  output logic charge_control_relay,
  output logic output_fault_relay
);
  localparam int TW = 48;
  initial begin
    if (VW < 1 || VW > 16) $error("gtr_top: VW must be 1..16");
    if (LBX_QUAL_CYC < 1 || LCR_REACT_CYC < 1 || MIN_CYC < 1) $error("gtr_top: counts must be positive");
  end

  // Registers
  logic [2:0] ctrl_r;
  logic [VW-1:0] high_transfer_volts_r, low_transfer_volts_r;
  logic [VW-1:0] hi_cut_r, lo_cut_r;
  logic [10:0] begin_hm_r, end_hm_r;
  logic [VW-1:0] lcr_on_r, lcr_off_r, ccr_on_r, ccr_off_r;
  logic [7:0] lcr_dly_min_r, ccr_dly_min_r;
  logic ack_r;

  function automatic logic [VW-1:0] clamp_v(input logic [VW-1:0] v, input logic [VW-1:0] lo,
                                             input logic [VW-1:0] hi);
    if (v > hi) return hi;
    if (v < lo) return lo;
    return v;
  endfunction

  // Hour 0..23, minute 0..59; out-of-range writes saturate
  function automatic logic [10:0] hm_pack(input logic [31:0] d);
    logic [4:0] h;
    logic [5:0] m;
    h = (d[12:8] > 5'd23) ? 5'd23 : d[12:8];
    m = (d[5:0] > 6'd59) ? 6'd59 : d[5:0];
    return {h, m};
  endfunction

  function automatic logic [10:0] hm_minutes(input logic [10:0] hm);
    return 11'(hm[10:6]) * 11'h03c + 11'(hm[5:0]);
  endfunction

  // One-cycle wait state: requests are answered on the second edge
  wire logic bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack_r;
  wire logic wr_go = avs_write && ack_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else if (clk_en) begin
      ack_r <= bus_req && !ack_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r <= `GTR_CTRL_RST;
    end else if (clk_en && wr_go && avs_address == `GTR_ADDR_CTRL) begin
      ctrl_r <= avs_writedata[2:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hi_cut_r <= '1;
      lo_cut_r <= '0;
    end else if (clk_en && wr_go && avs_address == `GTR_ADDR_CUTOUT) begin
      hi_cut_r <= avs_writedata[16 +: VW];
      lo_cut_r <= avs_writedata[0 +: VW];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      high_transfer_volts_r <= '1;
      low_transfer_volts_r <= '0;
    end else if (clk_en) begin
      if (wr_go && avs_address == `GTR_ADDR_HBX) begin
        high_transfer_volts_r <= clamp_v(avs_writedata[VW-1:0], lo_cut_r, hi_cut_r);
      end else if (wr_go && avs_address == `GTR_ADDR_LBX) begin
        low_transfer_volts_r <= clamp_v(avs_writedata[VW-1:0], lo_cut_r, hi_cut_r);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      begin_hm_r <= '0;
      end_hm_r <= '0;
    end else if (clk_en && wr_go && avs_address == `GTR_ADDR_TIMER) begin
      begin_hm_r <= hm_pack({19'h0, avs_writedata[12:0]});
      end_hm_r <= hm_pack({19'h0, avs_writedata[28:16]});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lcr_on_r <= '1;
      lcr_off_r <= '0;
      ccr_on_r <= '1;
      ccr_off_r <= '0;
      lcr_dly_min_r <= 8'h01;
      ccr_dly_min_r <= 8'h01;
    end else if (clk_en && wr_go) begin
      if (avs_address == `GTR_ADDR_LCR) begin
        lcr_on_r <= avs_writedata[16 +: VW];
        lcr_off_r <= avs_writedata[0 +: VW];
      end
      if (avs_address == `GTR_ADDR_CCR) begin
        ccr_on_r <= avs_writedata[16 +: VW];
        ccr_off_r <= avs_writedata[0 +: VW];
      end
      if (avs_address == `GTR_ADDR_DELAY) begin
        lcr_dly_min_r <= avs_writedata[7:0];
        ccr_dly_min_r <= avs_writedata[15:8];
      end
    end
  end

  // Grid usage window
  logic [10:0] now_m, beg_m, end_m;
  logic timer_en, in_window;
  gtr_pkg::gtr_mode_t mode;
  assign mode = ctrl_r[`GTR_CTRL_MODE_BIT] ? gtr_pkg::GTR_BATT_XFER : gtr_pkg::GTR_STANDBY;
  always_comb begin
    now_m = hm_minutes({tod_hour, tod_min});
    beg_m = hm_minutes(begin_hm_r);
    end_m = hm_minutes(end_hm_r);
    timer_en = (beg_m != end_m);
    if (!timer_en) begin
      in_window = 1'b1;
    end else if (beg_m < end_m) begin
      in_window = (now_m >= beg_m) && (now_m < end_m);
    end else begin
      in_window = (now_m >= beg_m) || (now_m < end_m); // Window spans midnight
    end
  end

  // Qualification timers
  gtr_tick_if #(.W(TW)) lbx_q ();
  gtr_tick_if #(.W(TW)) lcr_on_q ();
  gtr_tick_if #(.W(TW)) lcr_off_q ();
  gtr_tick_if #(.W(TW)) ccr_on_q ();
  logic xfer_active;
  gtr_pkg::gtr_xfer_t xst_r;
  assign xfer_active = (mode == gtr_pkg::GTR_BATT_XFER);
  assign lbx_q.cond = xfer_active && (xst_r == gtr_pkg::GTR_ON_INV) &&
                      (batt_volts <= low_transfer_volts_r);
  assign lbx_q.limit = TW'(LBX_QUAL_CYC);
  assign lcr_on_q.cond = (batt_volts >= lcr_on_r) && !load_control_relay;
  assign lcr_on_q.limit = TW'(LCR_REACT_CYC);
  assign lcr_off_q.cond = (batt_volts <= lcr_off_r) && load_control_relay;
  assign lcr_off_q.limit = TW'(MIN_CYC) * TW'(lcr_dly_min_r);
  assign ccr_on_q.cond = (batt_comp_volts >= ccr_on_r) && !charge_control_relay;
  assign ccr_on_q.limit = TW'(MIN_CYC) * TW'(ccr_dly_min_r);

  gtr_qual_timer #(.W(TW)) u_lbx (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .q(lbx_q));
  gtr_qual_timer #(.W(TW)) u_lcr_on (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .q(lcr_on_q));
  gtr_qual_timer #(.W(TW)) u_lcr_off (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .q(lcr_off_q));
  gtr_qual_timer #(.W(TW)) u_ccr_on (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .q(ccr_on_q));

  // Transfer state for battery transfer mode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      xst_r <= gtr_pkg::GTR_ON_INV;
    end else if (clk_en) begin
      if (!xfer_active) begin
        xst_r <= gtr_pkg::GTR_ON_INV;
      end else begin
        case (xst_r)
          gtr_pkg::GTR_ON_INV: begin
            if (lbx_q.done) xst_r <= gtr_pkg::GTR_ON_GRID;
          end
          gtr_pkg::GTR_ON_GRID: begin
            if (batt_volts >= high_transfer_volts_r) xst_r <= gtr_pkg::GTR_ON_INV;
          end
          default: xst_r <= gtr_pkg::GTR_ON_INV;
        endcase
      end
    end
  end

  // Decision outputs; grid availability is required to pass through
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      grid_connect <= 1'b0;
      grid_charge <= 1'b0;
      grid_silent <= 1'b0;
    end else if (clk_en) begin
      if (xfer_active) begin
        grid_connect <= (xst_r == gtr_pkg::GTR_ON_GRID) && grid_present;
        grid_charge <= 1'b0;
        grid_silent <= 1'b0;
      end else begin
        grid_connect <= grid_present && grid_in_tol && in_window;
        grid_charge <= grid_present && grid_in_tol && in_window && !ctrl_r[`GTR_CTRL_SILENT_BIT];
        grid_silent <= grid_present && grid_in_tol && in_window && ctrl_r[`GTR_CTRL_SILENT_BIT];
      end
    end
  end

  // Relays ignore inverter on/off state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      load_control_relay <= 1'b0;
      charge_control_relay <= 1'b0;
      output_fault_relay <= 1'b0;
    end else if (clk_en) begin
      if (lcr_on_q.done) load_control_relay <= 1'b1;
      else if (lcr_off_q.done) load_control_relay <= 1'b0;
      if (batt_comp_volts <= ccr_off_r) charge_control_relay <= 1'b0;
      else if (ccr_on_q.done) charge_control_relay <= 1'b1;
      // Cooldown drive opens the shared contactor while the request stands
      output_fault_relay <= ctrl_r[`GTR_CTRL_FAULT_BIT] ? !cooldown_req : inv_output_ok;
    end
  end

  // Read data registered at the first edge, ready for the answering edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      avs_readdata <= '0;
    end else if (clk_en && avs_read && !ack_r) begin
      case (avs_address)
        `GTR_ADDR_CTRL: avs_readdata <= {29'h0, ctrl_r};
        `GTR_ADDR_HBX: avs_readdata <= 32'(high_transfer_volts_r);
        `GTR_ADDR_LBX: avs_readdata <= 32'(low_transfer_volts_r);
        `GTR_ADDR_CUTOUT: avs_readdata <= (32'(hi_cut_r) << 16) | 32'(lo_cut_r);
        `GTR_ADDR_TIMER: avs_readdata <= {3'h0, end_hm_r[10:6], 2'h0, end_hm_r[5:0],
                                          3'h0, begin_hm_r[10:6], 2'h0, begin_hm_r[5:0]};
        `GTR_ADDR_LCR: avs_readdata <= (32'(lcr_on_r) << 16) | 32'(lcr_off_r);
        `GTR_ADDR_CCR: avs_readdata <= (32'(ccr_on_r) << 16) | 32'(ccr_off_r);
        `GTR_ADDR_DELAY: avs_readdata <= {16'h0, ccr_dly_min_r, lcr_dly_min_r};
        `GTR_ADDR_STATUS: avs_readdata <= {24'h0, timer_en, in_window, xst_r == gtr_pkg::GTR_ON_GRID,
                                           output_fault_relay, charge_control_relay, load_control_relay,
                                           grid_charge, grid_connect};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end
endmodule
